// File: acs_host_model.sv
// acs_host_model: host side of the register port and restart pin
// assumes the sequencer's clock; the bench calls its tasks
`timescale 1ns/1ps
`default_nettype none
module acs_host_model
    import acs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [31:0] reg_rdata,
    output logic      [3:0]  reg_addr,
    output logic      [31:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic             filt_restart_n
);
    // idle port at time zero
    initial begin
        reg_addr = 4'hf;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        filt_restart_n = 1'b1;
    end
    // one-cycle write; idle bus shows inverted values, not stale ones
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~v;
    endtask
    // one-cycle read; data taken at the edge that closes the answer cycle
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        v = reg_rdata;
    endtask
    // calibration command, ready ignored for one modulator cycle
    task automatic cal(input logic [2:0] code);
        wr(ACS_A_MODE, 32'(code));
        repeat (ACS_MOD_DIV) @(posedge clk);
        @(negedge clk);
    endtask
    // short low pulse on the filter restart pin
    task automatic restart();
        @(posedge clk);
        filt_restart_n <= 1'b0;
        repeat (4) @(posedge clk);
        filt_restart_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// File: acs_pkg.sv
// acs_pkg: constants and types for the converter calibration sequencer
// assumes a single 20 MHz master clock feeds every user of this package
package acs_pkg;
    localparam int          ACS_CLK_HZ      = 20_000_000;
    // modulator cycle is master clock / 256
    localparam int          ACS_MOD_DIV     = 256;
    // modulator cycles per output word, default first-notch setting
    localparam int          ACS_NOTCH_DEF   = 16'h0064;
    localparam int          ACS_ACC_W       = 33;
    // output words per calibration kind
    localparam int          ACS_DUR_SELF    = 9;
    localparam int          ACS_DUR_SYS     = 4;
    localparam int          ACS_DUR_BG      = 6;
    localparam logic [2:0]  ACS_MD_NORMAL   = 3'h0;
    localparam logic [2:0]  ACS_MD_SELF     = 3'h1;
    localparam logic [2:0]  ACS_MD_SYS_ZERO = 3'h2;
    localparam logic [2:0]  ACS_MD_SYS_FULL = 3'h3;
    localparam logic [2:0]  ACS_MD_SYS_OFS  = 3'h4;
    localparam logic [2:0]  ACS_MD_BG       = 3'h5;
    // register map, word offsets
    localparam logic [3:0]  ACS_A_MODE      = 4'h0;
    localparam logic [3:0]  ACS_A_CFG       = 4'h1;
    localparam logic [3:0]  ACS_A_OFS       = 4'h2;
    localparam logic [3:0]  ACS_A_GAIN      = 4'h3;
    localparam logic [3:0]  ACS_A_DATA      = 4'h4;
    localparam logic [3:0]  ACS_A_STAT      = 4'h5;
    // gain coefficient 1.0 in Q1.23
    localparam logic [23:0] ACS_GAIN_RST    = 24'h80_0000;
    localparam logic [23:0] ACS_OFS_RST     = 24'h00_0000;
    typedef enum logic [1:0] { ACS_SRC_AIN, ACS_SRC_ZERO, ACS_SRC_REF } acs_src_t;
    typedef struct packed {
        logic       bipolar;
        logic       wide;
        logic [2:0] pga_gain;
        logic [15:0] notch;
    } acs_cfg_t;
endpackage

// File: acs_sequencer.sv
// acs_sequencer: conversion timing, filter restart, calibration sequencing, correction
// assumes a modulator bitstream on the same clock and a host on the plain register port
//
// Notes on behaviour
// - converts free running, no start command
// - result word refreshed each notch period
// - all timing counted from master clock
// - restart input falling edge clears filter
// - common restart aligns several devices
// - any calibration command clears filter
// - background mode follows config changes itself
// - zero and full readings give slope
// - 33-bit arithmetic, 16 or 24 out
// - host writes offset and gain coefficients
// - subtract offset, then multiply by gain
// - ready low marks calibration done
// - ready forced high within one modulator cycle
// - mode 001 starts self calibration
// - self cal: shorted node, then reference
// - ready low only after filter resettles
// - self cal accounts for selected gain
// - bipolar cal uses midscale and full scale
// - system cal zero step then full step
// - mode 100 system offset calibration
// - mode 101 background, rate cut by six
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int NOTCH_DEF = ACS_NOTCH_DEF
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        filt_restart_n,
    input  wire logic        mod_bit,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic      [1:0]  mod_src_sel,
    output logic      [2:0]  pga_gain,
    output logic             result_ready_n,
    output logic      [23:0] result_data
);
    // reset release through two flops
    logic rst_s1_ff, rst_s2_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    wire logic rst_i_n = rst_s2_ff;

    // pin synchronisers for restart and modulator bit
    logic sy1_ff, sy2_ff, sy3_ff, mb1_ff, mb2_ff;
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            sy1_ff <= 1'b1;
            sy2_ff <= 1'b1;
            sy3_ff <= 1'b1;
            mb1_ff <= 1'b0;
            mb2_ff <= 1'b0;
        end else if (clk_en) begin
            sy1_ff <= filt_restart_n;
            sy2_ff <= sy1_ff;
            sy3_ff <= sy2_ff;
            mb1_ff <= mod_bit;
            mb2_ff <= mb1_ff;
        end
    end
    wire logic sync_fall = sy3_ff & ~sy2_ff;

    // registers
    logic [2:0]  mode_ff;
    acs_cfg_t    cfg_ff;
    logic [23:0] ofs_ff, gain_ff;
    logic [23:0] data_ff;
    logic        busy_ff;
    logic        ready_n_ff;
    logic [31:0] rdata_ff;

    wire logic wr_mode  = reg_wr & (reg_addr == ACS_A_MODE);
    wire logic wr_cfg   = reg_wr & (reg_addr == ACS_A_CFG);
    wire logic wr_ofs   = reg_wr & (reg_addr == ACS_A_OFS);
    wire logic wr_gain  = reg_wr & (reg_addr == ACS_A_GAIN);
    wire logic cal_cmd  = wr_mode & (reg_wdata[2:0] != ACS_MD_NORMAL) & (reg_wdata[2:0] <= ACS_MD_BG);
    wire logic cfg_chg  = wr_cfg & (reg_wdata[20:0] != cfg_ff);
    wire logic bg_mode  = (mode_ff == ACS_MD_BG);
    wire logic filt_clr = sync_fall | cal_cmd | (bg_mode & cfg_chg);

    // modulator cycle and word timers, all from clk
    logic [7:0]  mcnt_ff;
    logic [15:0] wcnt_ff;
    wire logic mod_tick  = (mcnt_ff == 8'(ACS_MOD_DIV - 1));
    wire logic word_tick = mod_tick & (wcnt_ff == (cfg_ff.notch - 16'h0001));
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            mcnt_ff <= 8'h00;
            wcnt_ff <= 16'h0000;
        end else if (clk_en) begin
            if (filt_clr) begin
                mcnt_ff <= 8'h00;
                wcnt_ff <= 16'h0000;
            end else begin
                mcnt_ff <= mcnt_ff + 8'h01;
                if (word_tick) begin
                    wcnt_ff <= 16'h0000;
                end else if (mod_tick) begin
                    wcnt_ff <= wcnt_ff + 16'h0001;
                end
            end
        end
    end

    // filter: counts ones over one notch period, 33-bit accumulator
    logic [ACS_ACC_W-1:0] acc_ff, raw_ff;
    logic                 raw_vld_ff;
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            acc_ff     <= '0;
            raw_ff     <= '0;
            raw_vld_ff <= 1'b0;
        end else if (clk_en) begin
            raw_vld_ff <= word_tick & ~filt_clr;
            if (filt_clr) begin
                acc_ff <= '0;
            end else if (word_tick) begin
                raw_ff <= acc_ff + ACS_ACC_W'(mb2_ff);
                acc_ff <= '0;
            end else begin
                acc_ff <= acc_ff + ACS_ACC_W'(mb2_ff);
            end
        end
    end

    // calibration sequencer
    typedef enum logic [2:0] { ACS_RUN, ACS_ZERO, ACS_FULL, ACS_SETTLE, ACS_BG_ZERO, ACS_BG_FULL } acs_state_t;
    acs_state_t st_ff, nxt_st;
    logic [3:0] ocnt_ff;
    logic [3:0] step_len;
    logic [2:0] bg_cnt_ff;
    logic [ACS_ACC_W-1:0] zero_ff;
    wire logic [ACS_ACC_W-1:0] span = raw_ff - zero_ff;
    // scale factor: full-scale code over measured span, gain folded in
    wire logic [23:0] full_code = cfg_ff.bipolar ? 24'h40_0000 : 24'h80_0000;
    wire logic [23:0] new_gain  = (span[23:0] == 24'h00_0000) ? gain_ff :
                                  24'(({full_code, 23'h0} >> cfg_ff.pga_gain) / {23'h0, span[23:0]});
    wire logic [23:0] mid_ofs   = cfg_ff.bipolar ? 24'(raw_ff - ACS_ACC_W'(cfg_ff.notch) * 33'h0_0080)
                                                 : raw_ff[23:0];

    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ACS_RUN:     nxt_st = (bg_mode && raw_vld_ff && bg_cnt_ff == 3'(ACS_DUR_BG - 1)) ?
                                  ACS_BG_ZERO : ACS_RUN;
            ACS_ZERO:    if (raw_vld_ff && ocnt_ff == step_len) begin
                             nxt_st = (mode_ff == ACS_MD_SYS_ZERO) ? ACS_SETTLE : ACS_FULL;
                         end
            ACS_FULL:    if (raw_vld_ff && ocnt_ff == step_len) begin
                             nxt_st = ACS_SETTLE;
                         end
            ACS_SETTLE:  if (raw_vld_ff && ocnt_ff == step_len) begin
                             nxt_st = ACS_RUN;
                         end
            ACS_BG_ZERO: if (raw_vld_ff) begin
                             nxt_st = ACS_BG_FULL;
                         end
            ACS_BG_FULL: if (raw_vld_ff) begin
                             nxt_st = ACS_RUN; // back to input conversions
                         end
            default:     nxt_st = ACS_RUN;
        endcase
        if (!bg_mode && (st_ff == ACS_BG_ZERO || st_ff == ACS_BG_FULL)) begin
            nxt_st = ACS_RUN;
        end
    end
    // self and offset phases span a third of the documented duration, system zero and full phases half
    assign step_len = (mode_ff == ACS_MD_SYS_ZERO || mode_ff == ACS_MD_SYS_FULL) ?
                      4'(ACS_DUR_SYS / 2) : 4'(ACS_DUR_SELF / 3);

    // step entry on command, sample capture per phase
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            st_ff     <= ACS_RUN;
            ocnt_ff   <= 4'h1;
            zero_ff   <= '0;
            busy_ff   <= 1'b0;
            bg_cnt_ff <= 3'h0;
        end else if (clk_en) begin
            if (cal_cmd) begin
                busy_ff   <= (reg_wdata[2:0] != ACS_MD_BG);
                ocnt_ff   <= 4'h1;
                bg_cnt_ff <= 3'h0;
                st_ff   <= (reg_wdata[2:0] == ACS_MD_BG) ? ACS_BG_ZERO :
                           (reg_wdata[2:0] == ACS_MD_SYS_FULL) ? ACS_FULL : ACS_ZERO;
            end else begin
                st_ff <= nxt_st;
                if (nxt_st != st_ff) begin
                    ocnt_ff <= 4'h1;
                end else if (raw_vld_ff) begin
                    ocnt_ff <= ocnt_ff + 4'h1;
                end
                if (st_ff == ACS_SETTLE && nxt_st == ACS_RUN) begin
                    busy_ff <= 1'b0;
                end
                if ((st_ff == ACS_ZERO || st_ff == ACS_BG_ZERO) && nxt_st != st_ff) begin
                    zero_ff <= raw_ff;
                end
                if (raw_vld_ff && bg_mode) begin
                    bg_cnt_ff <= (bg_cnt_ff == 3'(ACS_DUR_BG - 1)) ? 3'h0 : bg_cnt_ff + 3'h1;
                end
            end
        end
    end

    // coefficient and mode registers, host writes and calibration updates
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            mode_ff <= ACS_MD_NORMAL;
            cfg_ff  <= '{bipolar: 1'b0, wide: 1'b1, pga_gain: 3'h0, notch: 16'(NOTCH_DEF)};
            ofs_ff  <= ACS_OFS_RST;
            gain_ff <= ACS_GAIN_RST;
        end else if (clk_en) begin
            if (wr_mode) begin
                mode_ff <= reg_wdata[2:0];
            end
            if (wr_cfg) begin
                cfg_ff <= reg_wdata[20:0];
            end
            if (wr_ofs) begin
                ofs_ff <= reg_wdata[23:0];
            end else if (st_ff == ACS_ZERO && nxt_st != st_ff && !cal_cmd) begin
                ofs_ff <= (mode_ff == ACS_MD_SELF) ? mid_ofs : raw_ff[23:0];
            end else if (st_ff == ACS_BG_ZERO && nxt_st != st_ff && !cal_cmd) begin
                ofs_ff <= mid_ofs;
            end
            if (wr_gain) begin
                gain_ff <= reg_wdata[23:0];
            end else if ((st_ff == ACS_FULL || st_ff == ACS_BG_FULL) && nxt_st != st_ff && !cal_cmd) begin
                gain_ff <= new_gain;
            end
        end
    end

    // correction: subtract offset then scale, 33-bit signed, 16 or 24 out
    wire logic signed [ACS_ACC_W-1:0] diff = $signed(raw_ff - ACS_ACC_W'(ofs_ff));
    wire logic signed [57:0] prod = diff * $signed({1'b0, gain_ff});
    wire logic [23:0] corr = prod[46:23];
    wire logic [23:0] out_word = cfg_ff.wide ? corr : {8'h00, corr[23:8]};
    // background: zero word, full word, four input words, last one published
    wire logic publish = raw_vld_ff & ~busy_ff & (st_ff == ACS_RUN) &
                         (~bg_mode | (bg_cnt_ff == 3'(ACS_DUR_BG - 1)));

    // result word and ready line
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            data_ff    <= 24'h00_0000;
            ready_n_ff <= 1'b1;
        end else if (clk_en) begin
            if (cal_cmd) begin
                ready_n_ff <= 1'b1;
            end else if (st_ff == ACS_SETTLE && nxt_st == ACS_RUN) begin
                ready_n_ff <= 1'b0;
            end else if (publish) begin
                data_ff    <= out_word;
                ready_n_ff <= 1'b0;
            end else if (reg_rd && reg_addr == ACS_A_DATA) begin
                ready_n_ff <= 1'b1;
            end
        end
    end

    // read mux, data valid one cycle after the strobe
    logic [31:0] rd_mux;
    assign rd_mux = (reg_addr == ACS_A_MODE) ? {29'h0, mode_ff} :
                    (reg_addr == ACS_A_CFG)  ? {11'h0, cfg_ff}  :
                    (reg_addr == ACS_A_OFS)  ? {8'h00, ofs_ff}  :
                    (reg_addr == ACS_A_GAIN) ? {8'h00, gain_ff} :
                    (reg_addr == ACS_A_DATA) ? {8'h00, data_ff} :
                    (reg_addr == ACS_A_STAT) ? {27'h0, 3'(st_ff), busy_ff, ready_n_ff} : 32'h0000_0000;
    always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            rdata_ff <= 32'h0000_0000;
        end else if (clk_en) begin
            rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // modulator input steering during calibration phases
    acs_src_t src;
    assign src = (st_ff == ACS_FULL && mode_ff == ACS_MD_SYS_FULL) ? ACS_SRC_AIN :
                 (st_ff == ACS_FULL || st_ff == ACS_BG_FULL) ? ACS_SRC_REF :
                 ((st_ff == ACS_ZERO && mode_ff == ACS_MD_SELF) || st_ff == ACS_BG_ZERO) ? ACS_SRC_ZERO :
                 ACS_SRC_AIN;
    assign mod_src_sel    = src;
    assign pga_gain       = cfg_ff.pga_gain;
    assign result_ready_n = ready_n_ff;
    assign result_data    = data_ff;
    assign reg_rdata      = rdata_ff;
endmodule
`default_nettype wire

// File: acs_sequencer_checker.sv
// acs_sequencer_checker: port-level properties of the sequencer
// assumes a bind onto acs_sequencer, one clock domain
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_checker
    import acs_pkg::*;
#(
    parameter int NOTCH_DEF = ACS_NOTCH_DEF
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [1:0]  mod_src_sel,
    input wire logic [2:0]  pga_gain,
    input wire logic        result_ready_n,
    input wire logic [23:0] result_data
);
    logic [2:0] mode_ff;
    wire        wr_mode = reg_wr && clk_en && reg_addr == ACS_A_MODE;
    wire        rd_ok   = reg_rd && clk_en;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // last mode code written by the host
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            mode_ff <= ACS_MD_NORMAL;
        else if (wr_mode)
            mode_ff <= reg_wdata[2:0];
    end
    // offset write followed by its read-back
    sequence s_ofs_wr_rd;
        reg_wr && clk_en && reg_addr == ACS_A_OFS ##2 rd_ok && reg_addr == ACS_A_OFS;
    endsequence
    sequence s_self;
        wr_mode && reg_wdata[2:0] == ACS_MD_SELF;
    endsequence
    property p_cal_busy; wr_mode && reg_wdata[2:0] inside {[3'h1:3'h4]} |=> result_ready_n; endproperty
    a_cal_busy: assert property (p_cal_busy) else $error("ready not raised by command");
    property p_self_zero; s_self |=> (mod_src_sel == ACS_SRC_ZERO) [*8]; endproperty
    a_self_zero: assert property (p_self_zero) else $error("self cal not on shorted node");
    property p_sys_ain; wr_mode && reg_wdata[2:0] inside {3'h2, 3'h4} |=> (mod_src_sel == ACS_SRC_AIN) [*4]; endproperty
    a_sys_ain: assert property (p_sys_ain) else $error("system zero not from input");
    property p_cal_quiet;
        mod_src_sel != ACS_SRC_AIN && mode_ff != ACS_MD_BG && $past(mode_ff) != ACS_MD_BG
            |-> result_ready_n && $stable(result_data);
    endproperty
    a_cal_quiet: assert property (p_cal_quiet) else $error("result during calibration");
    property p_rd_idle; !rd_ok |=> reg_rdata == 32'h0000_0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
    property p_unmapped; rd_ok && reg_addr > ACS_A_STAT |=> reg_rdata == 32'h0000_0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_gain_out; reg_wr && clk_en && reg_addr == ACS_A_CFG |=> pga_gain == $past(reg_wdata[18:16]); endproperty
    a_gain_out: assert property (p_gain_out) else $error("gain output not from config");
    property p_ofs_back; s_ofs_wr_rd |=> reg_rdata[23:0] == $past(reg_wdata[23:0], 3); endproperty
    a_ofs_back: assert property (p_ofs_back) else $error("offset read-back wrong");
endmodule
bind acs_sequencer acs_sequencer_checker #(.NOTCH_DEF(NOTCH_DEF)) u_chk (.clk, .rst_n, .clk_en,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mod_src_sel, .pga_gain, .result_ready_n,
    .result_data);
`default_nettype wire

// File: test_acs_sequencer.sv
// test_acs_sequencer: self-checking bench for the calibration sequencer
// assumes acs_host_model as host and a fixed toggling modulator stream
`timescale 1ns/1ps
`default_nettype none
module test_acs_sequencer
    import acs_pkg::*;
;
    localparam int WORD = 2 * ACS_MOD_DIV; // clocks per word at notch 2
    logic        clk, rst_n, clk_en, mod_bit;
    wire  [3:0]  reg_addr;
    wire  [31:0] reg_wdata, reg_rdata;
    wire         reg_wr, reg_rd, filt_restart_n, result_ready_n;
    wire  [1:0]  mod_src_sel;
    wire  [2:0]  pga_gain;
    wire  [23:0] result_data;
    logic [31:0] d;
    int          n_fail, samples_checked, cyc, t0, n;
    bit          saw_ref;
    logic [2:0]  codes [4] = '{ACS_MD_SELF, ACS_MD_SYS_ZERO, ACS_MD_SYS_FULL, ACS_MD_SYS_OFS};
    int          durs [4] = '{ACS_DUR_SELF, ACS_DUR_SYS, ACS_DUR_SYS, ACS_DUR_SELF};
    acs_sequencer #(.NOTCH_DEF(2)) uut (.clk, .rst_n, .clk_en, .filt_restart_n, .mod_bit, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mod_src_sel, .pga_gain, .result_ready_n, .result_data);
    acs_host_model host (.clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .filt_restart_n);
    always #25 clk = ~clk;
    // modulator stream and cycle count, with a run limit
    always @(posedge clk) begin
        mod_bit <= cyc[0] ^ cyc[3];
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("counts: %0d checked, %0d failed", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // wait for a published word, noting any reference phase
    task automatic wait_rdy();
        n = 0;
        while (result_ready_n !== 1'b0 && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
            if (mod_src_sel === ACS_SRC_REF) saw_ref = 1;
        end
    endtask
    // clocks between two consecutive published words
    task automatic period(output int p);
        wait_rdy();
        host.rd(ACS_A_DATA, d);
        wait_rdy();
        t0 = cyc;
        host.rd(ACS_A_DATA, d);
        wait_rdy();
        p = cyc - t0;
    endtask
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        mod_bit = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // reset value, read-back, unmapped place, gain output
        host.rd(ACS_A_GAIN, d);
        check("gain reset", d, 32'(ACS_GAIN_RST));
        host.wr(ACS_A_OFS, 32'h0000_1234);
        host.rd(ACS_A_OFS, d);
        check("offset", d, 32'h0000_1234);
        host.wr(4'hf, 32'hffff_ffff);
        host.rd(4'hf, d);
        check("unmapped", d, 32'h0000_0000);
        host.wr(ACS_A_OFS, 32'h0000_0000);
        host.wr(ACS_A_CFG, 32'h0003_0002);
        @(negedge clk);
        check("pga gain", 32'(pga_gain), 32'h0000_0003);
        $display("test registers done");
        // free-running word rate follows the notch
        host.restart();
        period(n);
        check("period notch 2", n, WORD);
        host.wr(ACS_A_CFG, 32'h0003_0004);
        period(n);
        check("period notch 4", n, 2 * WORD);
        host.wr(ACS_A_CFG, 32'h0003_0002);
        // restart shortly before a due word pushes it back
        period(n);
        host.rd(ACS_A_DATA, d);
        repeat (WORD - 100) @(posedge clk);
        t0 = cyc;
        host.restart();
        wait_rdy();
        check("restart delay", 32'(cyc - t0 >= WORD), 32'h0000_0001);
        $display("test rate done");
        // each calibration code from 001 to 100, issued while ready is low
        foreach (codes[i]) begin
            wait_rdy();
            saw_ref = 0;
            t0 = cyc;
            host.cal(codes[i]);
            check("busy", 32'(result_ready_n), 32'h0000_0001);
            wait_rdy();
            check("cal words", 32'((cyc - t0 + WORD / 2) / WORD), 32'(durs[i]));
            check("reference", 32'(saw_ref), 32'(i == 0 || i == 3));
            host.rd(ACS_A_DATA, d);
        end
        $display("test calibration done");
        // unknown mode code starts nothing
        wait_rdy();
        host.wr(ACS_A_MODE, 32'h0000_0007);
        repeat (2) @(posedge clk);
        #1;
        check("code 7 idle", 32'(result_ready_n), 32'h0000_0000);
        // background mode keeps one word in six until the mode changes
        host.wr(ACS_A_MODE, 32'(ACS_MD_BG));
        period(n);
        check("background period", n, ACS_DUR_BG * WORD);
        host.wr(ACS_A_MODE, 32'h0000_0000);
        period(n);
        check("normal period", n, WORD);
        check("normal source", 32'(mod_src_sel), 32'(ACS_SRC_AIN));
        $display("test modes done");
        conclude();
    end
endmodule
`default_nettype wire
